// file: core/sbl_regs.svh
// Register offsets, field positions, reset values and timing counts of the boot loader.
`ifndef SBL_REGS_SVH
`define SBL_REGS_SVH

`define SBL_ADDR_W 8
`define SBL_OFF_SECURITY 8'h00
`define SBL_OFF_PROG_ADDR 8'h04
`define SBL_OFF_PROG_DATA 8'h08
`define SBL_OFF_PROG_CTRL 8'h0C
`define SBL_OFF_STATUS 8'h10
`define SBL_OFF_ID_ADDR 8'h14
`define SBL_OFF_ID_DATA 8'h18
`define SBL_OFF_ID_CTRL 8'h1C

`define SBL_PORT_ID_ADDR 32'h0010_0200
`define SBL_PORT_ID_DATA 32'h0020_0100
`define SBL_PORT_ID_CTRL 32'h0010_0300

`define SBL_SEC_JTAG_OFF 0
`define SBL_SEC_LINK_OFF 1
`define SBL_SEC_SECURE_BOOT 5
`define SBL_SEC_REDUNDANT 7
`define SBL_SEC_LOCK0 8
`define SBL_SEC_MASTER_LOCK 12
`define SBL_SEC_JTAG_OTP_OFF 13
`define SBL_SEC_DEBUG_OFF 14
`define SBL_SEC_GP_LO 15
`define SBL_SEC_GP_HI 21
`define SBL_SEC_RESET 32'h0000_7F03

`define SBL_ST_DONE 0
`define SBL_ST_FAIL 1
`define SBL_ST_REFUSED 2
`define SBL_ST_SECURE 3
`define SBL_CTRL_GO 0

`define SBL_OTP_AW 11
`define SBL_OTP_ROWS_PER_SECTOR 512
`define SBL_OTP_SECTORS 4
`define SBL_SEC_ROW 11'h7FF
`define SBL_OTP_BOOT_ROW 11'h000

`define SBL_CRC_POLY 32'hEDB8_8320
`define SBL_CRC_INIT 32'hFFFF_FFFF
`define SBL_CRC_BYPASS 32'h0D15_AB1E

`define SBL_CLK_PERIOD_NS 10
`define SBL_BOOT_DELAY_MIN_NS 15000
`define SBL_BOOT_DELAY_CYC ((`SBL_BOOT_DELAY_MIN_NS + `SBL_CLK_PERIOD_NS - 1) / `SBL_CLK_PERIOD_NS)

`endif

// file: core/sbl_pkg.sv
// Types shared by the boot loader and its surroundings.
package sbl_pkg;

    typedef enum logic [3:0] {
        SBL_RESET,
        SBL_WAIT,
        SBL_SEC_REQ,
        SBL_SEC_LATCH,
        SBL_LEN,
        SBL_PROG,
        SBL_CRC,
        SBL_CHECK,
        SBL_RUN,
        SBL_FAIL
    } sbl_state_e;

    typedef struct packed {
        logic we;
        logic [29:0] addr;
        logic [31:0] data;
    } sbl_ram_wr_s;

    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [31:0] data;
        logic [15:0] ctrl;
    } sbl_otp_prog_s;

endpackage

// file: core/sbl_loader.sv
// Boot image loader with security register and OTP programming ports.
`timescale 1ns/1ps
`default_nettype none
`include "sbl_regs.svh"

// Functional notes
// R1: Reset pin low holds reset, pulls down GPIO.
// R2: Boot starts 15-150 us after reset release.
// R3: Board holds reset until IO rail stable 1 ms.
// R4: Bit 5 boots from OTP row 0, else flash.
// R5: Image is length, program words, then CRC.
// R6: CRC field 0x0D15AB1E skips the check.
// R7: Length and CRC assembled least significant byte first.
// R8: Program loads at RAM address 0, starts there.
// R9: CRC covers length word and program bytes only.
// R10: Reflected poly 0xEDB88320, init all ones, inverted.
// R11: Bit 0 disables JTAG.
// R12: Bit 1 refuses link access to processor state.
// R13: Bit 7 enables OTP redundant rows.
// R14: Bits 8 to 11 lock OTP sectors 0 to 3.
// R15: Bit 12 blocks all OTP programming.
// R16: Bit 13 denies JTAG all OTP access.
// R17: Bit 14 disables the debug sync pin.
// R18: Bits 21 to 15 are software general purpose.
// R19: Security register loaded from OTP at power-up.
// R20: OTP is four sectors of 512 32-bit rows.
// R21: Address, data and control programming ports with identifiers.
// R22: Board holds tile-2 link-boot strap high at release.
// R23: CRC mismatch reports failure and never starts program.
module sbl_loader #(
    parameter int RAM_AW = 15
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic rst_n_pin,
    output logic gpio_pulldown_en,
    input wire logic [`SBL_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic otp_rd_en,
    output logic [`SBL_OTP_AW-1:0] otp_rd_addr,
    input wire logic [31:0] otp_rd_data,
    output sbl_pkg::sbl_otp_prog_s otp_prog,
    output logic flash_byte_req,
    input wire logic flash_byte_valid,
    input wire logic [7:0] flash_byte,
    output sbl_pkg::sbl_ram_wr_s ram_wr,
    output logic cpu_start,
    output logic [29:0] cpu_start_addr,
    output logic jtag_disable,
    output logic link_access_disable,
    output logic otp_redundant_en,
    output logic jtag_otp_disable,
    output logic debug_pin_disable
);
    import sbl_pkg::*;

    localparam logic [10:0] DELAY_CYC = 11'(`SBL_BOOT_DELAY_CYC);
    localparam logic [31:0] RAM_WORDS = 32'(64'(1) << RAM_AW);

    if (RAM_AW < 2 || RAM_AW > 30) begin : g_bad_aw
        $error("RAM_AW must lie between 2 and 30");
    end
    if (`SBL_OTP_ROWS_PER_SECTOR * `SBL_OTP_SECTORS != (1 << `SBL_OTP_AW)) begin : g_bad_otp
        $error("OTP geometry does not match its address width");
    end

    // Reset pin comes from outside the clock domain.
    // Both stages reset low, which holds the loader in reset.
    logic rst_meta;
    logic rst_sync;
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= rst_n_pin;
            rst_sync <= rst_meta;
        end
    end

    sbl_state_e state;
    logic [10:0] delay_cnt;
    logic [1:0] bcnt;
    logic [31:0] asm_word;
    logic [31:0] prog_len;
    logic [31:0] wcount;
    logic [31:0] crc;
    logic [31:0] sec;
    logic byte_vld;
    logic [7:0] byte_val;
    logic fetch_busy;
    logic otp_wait;
    logic [1:0] otp_bidx;
    logic [31:0] otp_word;
    logic [`SBL_OTP_AW-1:0] otp_ptr;
    logic [31:0] full_word;
    logic want_byte;
    logic byte_phase;
    logic secure_src;
    logic boot_done;
    logic boot_fail;
    logic prog_refused;
    logic [15:0] prog_addr;
    logic [31:0] prog_data;
    logic [15:0] prog_ctrl;
    logic prog_go;
    logic prog_blocked;
    logic refuse_evt;
    logic [1:0] prog_sector;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] x;
        x = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ `SBL_CRC_POLY) : (x >> 1); // R10
        end
        return x;
    endfunction

    assign secure_src = sec[`SBL_SEC_SECURE_BOOT];
    assign full_word = {byte_val, asm_word[31:8]}; // R7
    assign byte_phase = (state == SBL_LEN) || (state == SBL_PROG) || (state == SBL_CRC); // R5
    assign want_byte = byte_phase && !fetch_busy && !byte_vld;

    // Boot sequencer.
    always_ff @(posedge clk) begin
        if (srst || !rst_sync) begin
            state <= SBL_RESET; // R1
            delay_cnt <= 11'h000;
            bcnt <= 2'b00;
            asm_word <= 32'h0000_0000;
            prog_len <= 32'h0000_0000;
            wcount <= 32'h0000_0000;
            crc <= `SBL_CRC_INIT; // R10
        end else begin
            unique case (state)
                SBL_RESET: begin
                    state <= SBL_WAIT;
                end
                SBL_WAIT: begin
                    delay_cnt <= delay_cnt + 11'h001;
                    if (delay_cnt == DELAY_CYC - 11'h001) begin
                        state <= SBL_SEC_REQ; // R2
                    end
                end
                SBL_SEC_REQ: begin
                    state <= SBL_SEC_LATCH;
                end
                SBL_SEC_LATCH: begin
                    state <= SBL_LEN;
                end
                SBL_LEN, SBL_PROG, SBL_CRC: begin
                    if (byte_vld) begin
                        asm_word <= full_word;
                        bcnt <= bcnt + 2'b01;
                        if (state != SBL_CRC) begin
                            crc <= crc_byte(crc, byte_val); // R9
                        end
                        if (bcnt == 2'b11) begin
                            if (state == SBL_LEN) begin
                                prog_len <= full_word;
                                if (full_word == 32'h0000_0000) begin
                                    state <= SBL_CRC;
                                end else if (full_word > RAM_WORDS) begin
                                    state <= SBL_FAIL;
                                end else begin
                                    state <= SBL_PROG;
                                end
                            end else if (state == SBL_PROG) begin
                                wcount <= wcount + 32'h0000_0001;
                                if (wcount == prog_len - 32'h0000_0001) begin
                                    state <= SBL_CRC;
                                end
                            end else begin
                                state <= SBL_CHECK;
                            end
                        end
                    end
                end
                SBL_CHECK: begin
                    if (asm_word == `SBL_CRC_BYPASS // R6
                        || asm_word == ~crc) begin // R10
                        state <= SBL_RUN;
                    end else begin
                        state <= SBL_FAIL; // R23
                    end
                end
                SBL_RUN: begin
                    state <= SBL_RUN;
                end
                SBL_FAIL: begin
                    state <= SBL_FAIL;
                end
                default: begin
                    state <= SBL_FAIL;
                end
            endcase
        end
    end

    // Byte source: OTP words split LSB first, or the flash byte stream.
    // The OTP answers in the cycle of its read enable.
    always_ff @(posedge clk) begin
        if (srst || !rst_sync) begin
            otp_rd_en <= 1'b0;
            otp_rd_addr <= '0;
            flash_byte_req <= 1'b0;
            byte_vld <= 1'b0;
            byte_val <= 8'h00;
            fetch_busy <= 1'b0;
            otp_wait <= 1'b0;
            otp_bidx <= 2'b00;
            otp_word <= 32'h0000_0000;
            otp_ptr <= `SBL_OTP_BOOT_ROW; // R4
        end else begin
            otp_rd_en <= 1'b0;
            flash_byte_req <= 1'b0;
            byte_vld <= 1'b0;
            if (state == SBL_SEC_REQ) begin
                otp_rd_en <= 1'b1; // R19
                otp_rd_addr <= `SBL_SEC_ROW;
            end else if (want_byte) begin
                if (secure_src) begin // R4
                    if (otp_bidx == 2'b00) begin
                        otp_rd_en <= 1'b1;
                        otp_rd_addr <= otp_ptr;
                        otp_ptr <= otp_ptr + 11'h001;
                        fetch_busy <= 1'b1;
                        otp_wait <= 1'b1;
                    end else begin
                        byte_val <= otp_word[8*otp_bidx +: 8];
                        byte_vld <= 1'b1;
                        otp_bidx <= otp_bidx + 2'b01;
                    end
                end else begin
                    flash_byte_req <= 1'b1;
                    fetch_busy <= 1'b1;
                end
            end else if (otp_wait) begin
                otp_wait <= 1'b0;
                fetch_busy <= 1'b0;
                otp_word <= otp_rd_data;
                byte_val <= otp_rd_data[7:0];
                byte_vld <= 1'b1;
                otp_bidx <= 2'b01;
            end else if (fetch_busy && flash_byte_valid) begin
                fetch_busy <= 1'b0;
                byte_val <= flash_byte;
                byte_vld <= 1'b1;
            end
        end
    end

    // RAM loading and program start.
    always_ff @(posedge clk) begin
        if (srst || !rst_sync) begin
            ram_wr <= '0;
            cpu_start <= 1'b0;
            cpu_start_addr <= 30'h0000_0000; // R8
            gpio_pulldown_en <= 1'b1; // R1
        end else begin
            gpio_pulldown_en <= 1'b0;
            ram_wr.we <= 1'b0;
            cpu_start <= 1'b0;
            if (state == SBL_PROG && byte_vld && bcnt == 2'b11) begin
                ram_wr.we <= 1'b1;
                ram_wr.addr <= wcount[29:0]; // R8
                ram_wr.data <= full_word;
            end
            if (state == SBL_CHECK) begin
                cpu_start <= (asm_word == `SBL_CRC_BYPASS) // R23
                    || (asm_word == ~crc);
                cpu_start_addr <= 30'h0000_0000; // R8
            end
        end
    end

    // Security register: loaded from OTP, software owns only the general-purpose field.
    always_ff @(posedge clk) begin
        if (srst || !rst_sync) begin
            sec <= `SBL_SEC_RESET;
        end else if (state == SBL_SEC_LATCH) begin
            sec <= otp_rd_data; // R19
        end else if (reg_wr && reg_addr == `SBL_OFF_SECURITY) begin
            sec[`SBL_SEC_GP_HI:`SBL_SEC_GP_LO] <= // R18
                reg_wdata[`SBL_SEC_GP_HI:`SBL_SEC_GP_LO];
        end
    end

    assign jtag_disable = sec[`SBL_SEC_JTAG_OFF]; // R11
    assign link_access_disable = sec[`SBL_SEC_LINK_OFF]; // R12
    assign otp_redundant_en = sec[`SBL_SEC_REDUNDANT]; // R13
    assign jtag_otp_disable = sec[`SBL_SEC_JTAG_OTP_OFF]; // R16
    assign debug_pin_disable = sec[`SBL_SEC_DEBUG_OFF]; // R17

    // OTP programming ports.
    assign prog_sector = prog_addr[`SBL_OTP_AW-1:`SBL_OTP_AW-2]; // R20
    assign prog_go = reg_wr && reg_addr == `SBL_OFF_PROG_CTRL && reg_wdata[`SBL_CTRL_GO];
    assign prog_blocked = sec[`SBL_SEC_MASTER_LOCK] || sec[`SBL_SEC_LOCK0 + prog_sector] // R14 R15
        || (prog_addr[15:`SBL_OTP_AW] != '0);
    assign refuse_evt = prog_go && prog_blocked;

    always_ff @(posedge clk) begin
        if (srst) begin
            prog_addr <= 16'h0000;
            prog_data <= 32'h0000_0000;
            prog_ctrl <= 16'h0000;
            otp_prog <= '0;
        end else begin
            otp_prog.en <= 1'b0;
            if (reg_wr && reg_addr == `SBL_OFF_PROG_ADDR) begin
                prog_addr <= reg_wdata[15:0]; // R21
            end
            if (reg_wr && reg_addr == `SBL_OFF_PROG_DATA) begin
                prog_data <= reg_wdata; // R21
            end
            if (reg_wr && reg_addr == `SBL_OFF_PROG_CTRL) begin
                prog_ctrl <= reg_wdata[15:0]; // R21
            end
            if (prog_go && !prog_blocked) begin
                otp_prog.en <= 1'b1; // R15
                otp_prog.addr <= prog_addr;
                otp_prog.data <= prog_data;
                otp_prog.ctrl <= reg_wdata[15:0];
            end
        end
    end

    // Status flags; a refusal in the cycle of its clear stays set.
    always_ff @(posedge clk) begin
        if (srst) begin
            boot_done <= 1'b0;
            boot_fail <= 1'b0;
            prog_refused <= 1'b0;
        end else begin
            boot_done <= (state == SBL_RUN);
            boot_fail <= (state == SBL_FAIL); // R23
            if (refuse_evt) begin
                prog_refused <= 1'b1;
            end else if (reg_wr && reg_addr == `SBL_OFF_STATUS
                && reg_wdata[`SBL_ST_REFUSED]) begin
                prog_refused <= 1'b0;
            end
        end
    end

    // Register read port, data one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SBL_OFF_SECURITY: reg_rdata <= sec;
                `SBL_OFF_PROG_ADDR: reg_rdata <= {16'h0000, prog_addr};
                `SBL_OFF_PROG_DATA: reg_rdata <= prog_data;
                `SBL_OFF_PROG_CTRL: reg_rdata <= {16'h0000, prog_ctrl};
                `SBL_OFF_STATUS: reg_rdata <= {28'h000_0000, secure_src, prog_refused,
                                               boot_fail, boot_done};
                `SBL_OFF_ID_ADDR: reg_rdata <= `SBL_PORT_ID_ADDR; // R21
                `SBL_OFF_ID_DATA: reg_rdata <= `SBL_PORT_ID_DATA;
                `SBL_OFF_ID_CTRL: reg_rdata <= `SBL_PORT_ID_CTRL;
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// file: test/sbl_loader_asserts.sv
// Concurrent checks on the boot loader ports.
`timescale 1ns/1ps
`default_nettype none
`include "sbl_regs.svh"
module sbl_loader_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic rst_n_pin,
    input wire logic gpio_pulldown_en,
    input wire logic [`SBL_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic otp_rd_en,
    input wire logic [`SBL_OTP_AW-1:0] otp_rd_addr,
    input wire sbl_pkg::sbl_otp_prog_s otp_prog,
    input wire logic flash_byte_req,
    input wire sbl_pkg::sbl_ram_wr_s ram_wr,
    input wire logic cpu_start,
    input wire logic [29:0] cpu_start_addr,
    input wire logic jtag_disable,
    input wire logic link_access_disable,
    input wire logic otp_redundant_en,
    input wire logic jtag_otp_disable,
    input wire logic debug_pin_disable
);
    import sbl_pkg::*;
    logic [15:0] since;
    logic first;
    logic [29:0] wr_idx;
    logic prog_req_q;
    logic [15:0] ctrl_q;
    // Cycles since reset ended, whether the security row is still unread, next RAM word.
    always_ff @(posedge clk) begin
        if (srst || gpio_pulldown_en) begin
            since <= 16'h0000;
            first <= 1'b1;
            wr_idx <= 30'h0;
        end else begin
            since <= (since == 16'hFFFF) ? since : since + 16'h0001;
            if (otp_rd_en) first <= 1'b0;
            if (ram_wr.we) wr_idx <= wr_idx + 30'h1;
        end
    end
    always_ff @(posedge clk) begin
        prog_req_q <= reg_wr && reg_addr == `SBL_OFF_PROG_CTRL && reg_wdata[0];
        ctrl_q <= reg_wdata[15:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_pin_holds_reset: assert property (!rst_n_pin [*3] |=> gpio_pulldown_en)
        else $error("pull-down off while the reset pin is low");
    a_quiet_in_reset: assert property (gpio_pulldown_en |-> !cpu_start && !ram_wr.we)
        else $error("activity while held in reset");
    a_boot_delay: assert property (otp_rd_en && first |->
        otp_rd_addr == `SBL_SEC_ROW && since >= 16'd1495 && since <= 16'd15000)
        else $error("security row read at the wrong time or place");
    a_ram_in_order: assert property (ram_wr.we |-> ram_wr.addr == wr_idx)
        else $error("program word written out of order");
    a_start_at_zero: assert property (cpu_start |-> cpu_start_addr == 30'h0)
        else $error("start address not zero");
    a_sec_levels: assert property (reg_rd && reg_addr == `SBL_OFF_SECURITY |=>
        reg_rdata[0] == $past(jtag_disable) && reg_rdata[1] == $past(link_access_disable)
        && reg_rdata[7] == $past(otp_redundant_en) && reg_rdata[13] == $past(jtag_otp_disable)
        && reg_rdata[14] == $past(debug_pin_disable))
        else $error("security outputs differ from the register");
    a_prog_cause: assert property (otp_prog.en |->
        prog_req_q && otp_prog.ctrl == ctrl_q && otp_prog.addr[15:11] == 5'h00)
        else $error("programming pulse without a valid request");
    a_id_port: assert property (reg_rd && reg_addr == `SBL_OFF_ID_DATA |=>
        reg_rdata == `SBL_PORT_ID_DATA)
        else $error("data port identifier wrong");
endmodule
`default_nettype wire

// file: test/sbl_boot_mem.sv
// Behavioural boot flash and OTP array facing the loader.
`timescale 1ns/1ps
`default_nettype none
module sbl_boot_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire logic otp_rd_en,
    input wire logic [10:0] otp_rd_addr,
    output logic [31:0] otp_rd_data,
    input wire logic flash_byte_req,
    output logic flash_byte_valid,
    output logic [7:0] flash_byte
);
    // Four sectors of 512 rows; the security word sits in the top row.
    logic [31:0] otp [0:2047];
    logic [7:0] flash [0:255];
    int ptr = 0;
    int cnt = 0;
    logic pend = 1'b0;
    initial begin
        flash_byte = 8'h00;
        flash_byte_valid = 1'b0;
    end
    // Read data stand while the enable does; otherwise the inverse shows.
    always_comb begin
        otp_rd_data = otp_rd_en ? otp[otp_rd_addr] : ~otp[otp_rd_addr];
    end
    // Bytes come in image order after lat cycles, each word least significant byte first.
    always @(posedge clk) begin
        flash_byte_valid <= 1'b0;
        flash_byte <= ~flash_byte;
        if (rst) begin
            ptr = 0;
            pend = 1'b0;
        end else begin
            if (flash_byte_req) begin
                pend = 1'b1;
                cnt = lat;
            end
            if (pend && cnt <= 1) begin
                flash_byte_valid <= 1'b1;
                flash_byte <= flash[ptr[7:0]];
                ptr++;
                pend = 1'b0;
            end else if (pend) begin
                cnt--;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/secure_boot_image_loader_tb_top.sv
// Testbench for the boot loader: boot sources, image checks, security and programming.
`timescale 1ns/1ps
`default_nettype none
`include "sbl_regs.svh"
module secure_boot_image_loader_tb_top;
    import sbl_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rst_n_pin = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [3:0] lat = 4'h1;
    logic [31:0] ram [0:15];
    logic [31:0] cur_sec;
    int fail_count = 0;
    int checks = 0;
    int n_start = 0;
    int n_wr = 0;
    int n_prog = 0;
    int n_freq = 0;
    sbl_otp_prog_s otp_prog, last_prog;
    sbl_ram_wr_s ram_wr;
    logic gpio_pulldown_en, otp_rd_en, flash_byte_req, flash_byte_valid, cpu_start;
    logic jtag_disable, link_access_disable, otp_redundant_en, jtag_otp_disable;
    logic debug_pin_disable;
    logic [10:0] otp_rd_addr;
    logic [31:0] otp_rd_data, reg_rdata;
    logic [7:0] flash_byte;
    logic [29:0] cpu_start_addr;
    always #5 clk = ~clk;
    sbl_loader dut (.clk(clk), .srst(srst), .rst_n_pin(rst_n_pin),
        .gpio_pulldown_en(gpio_pulldown_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_rd_en(otp_rd_en),
        .otp_rd_addr(otp_rd_addr), .otp_rd_data(otp_rd_data), .otp_prog(otp_prog),
        .flash_byte_req(flash_byte_req), .flash_byte_valid(flash_byte_valid),
        .flash_byte(flash_byte), .ram_wr(ram_wr), .cpu_start(cpu_start),
        .cpu_start_addr(cpu_start_addr), .jtag_disable(jtag_disable),
        .link_access_disable(link_access_disable), .otp_redundant_en(otp_redundant_en),
        .jtag_otp_disable(jtag_otp_disable), .debug_pin_disable(debug_pin_disable));
    sbl_boot_mem u_mem (.clk(clk), .rst(srst || !rst_n_pin), .lat(lat), .otp_rd_en(otp_rd_en),
        .otp_rd_addr(otp_rd_addr), .otp_rd_data(otp_rd_data), .flash_byte_req(flash_byte_req),
        .flash_byte_valid(flash_byte_valid), .flash_byte(flash_byte));
    always @(posedge clk) begin
        if (cpu_start) n_start++;
        if (ram_wr.we) ram[ram_wr.addr[3:0]] = ram_wr.data;
        if (ram_wr.we) n_wr++;
        if (otp_prog.en) last_prog = otp_prog;
        if (otp_prog.en) n_prog++;
        if (flash_byte_req) n_freq++;
    end
    task automatic close_out();
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        rd(a, x);
        chk(x, exp);
    endtask
    // Reflected CRC step over one word, bit 0 first, which is byte order low to high.
    function automatic logic [31:0] crc_word(logic [31:0] c, logic [31:0] w);
        for (int k = 0; k < 32; k++) c = (c[0] ^ w[k]) ? (c >> 1) ^ `SBL_CRC_POLY : c >> 1;
        return c;
    endfunction
    // Mode 0 gives a good check word, 1 the bypass marker, 2 a corrupted check word.
    task automatic boot(input int n, input int mode, input logic [31:0] sec, input logic [3:0] l);
        logic [31:0] w, c, st;
        int s0, w0, f0;
        c = `SBL_CRC_INIT;
        for (int i = 0; i <= n + 1; i++) begin
            w = (i == 0) ? 32'(n) : 32'h1357_0000 + 32'(i) * 32'h0000_0101;
            if (i <= n) c = crc_word(c, w);
            else w = (mode == 1) ? `SBL_CRC_BYPASS : ~c ^ 32'(mode / 2);
            u_mem.otp[i] = w;
            for (int k = 0; k < 4; k++) u_mem.flash[4 * i + k] = w[8 * k +: 8];
        end
        u_mem.otp[`SBL_SEC_ROW] = sec;
        cur_sec = sec;
        lat = l;
        @(posedge clk);
        rst_n_pin <= 1'b0;
        repeat (6) @(posedge clk);
        chk({31'h0, gpio_pulldown_en}, 32'h1);
        s0 = n_start;
        w0 = n_wr;
        f0 = n_freq;
        rst_n_pin <= 1'b1;
        st = 32'h0;
        for (int t = 0; t < 300 && st[1:0] == 2'b00; t++) begin
            repeat (10) @(posedge clk);
            rd(`SBL_OFF_STATUS, st);
        end
        chk(st & 32'hB, {28'h0, sec[5], 1'b0, mode == 2, mode != 2});
        chk(32'(n_start - s0), 32'(mode != 2));
        chk({31'h0, n_freq == f0}, {31'h0, sec[5]});
        rc(`SBL_OFF_SECURITY, sec);
        chk({27'h0, jtag_disable, link_access_disable, otp_redundant_en, jtag_otp_disable,
            debug_pin_disable},
            {27'h0, sec[0], sec[1], sec[7], sec[13], sec[14]});
        if (mode != 2) begin
            chk(32'(n_wr - w0), 32'(n));
            for (int j = 0; j < n; j++) chk(ram[j], 32'h1357_0000 + 32'(j + 1) * 32'h0000_0101);
        end
    endtask
    task automatic prog(input logic [15:0] a);
        logic ok;
        logic [31:0] st;
        int p0;
        ok = !cur_sec[12] && !cur_sec[8 + a[10:9]] && a[15:11] == 5'h00;
        wr(`SBL_OFF_STATUS, 32'h4);
        p0 = n_prog;
        wr(`SBL_OFF_PROG_ADDR, {16'h0, a});
        wr(`SBL_OFF_PROG_DATA, {16'hC0DE, a});
        wr(`SBL_OFF_PROG_CTRL, 32'h0000_A5A1);
        repeat (2) @(posedge clk);
        chk(32'(n_prog - p0), {31'h0, ok});
        if (ok) chk({last_prog.addr, last_prog.ctrl}, {a, 16'hA5A1});
        if (ok) chk(last_prog.data, {16'hC0DE, a});
        rc(`SBL_OFF_PROG_DATA, {16'hC0DE, a});
        rd(`SBL_OFF_STATUS, st);
        chk({31'h0, st[2]}, {31'h0, !ok});
    endtask
    task automatic gp_write();
        logic [31:0] x;
        wr(`SBL_OFF_SECURITY, ~cur_sec);
        rd(`SBL_OFF_SECURITY, x);
        chk(x, (cur_sec & ~32'h003F_8000) | (~cur_sec & 32'h003F_8000));
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rc(`SBL_OFF_SECURITY, `SBL_SEC_RESET);
        rc(`SBL_OFF_ID_ADDR, `SBL_PORT_ID_ADDR);
        rc(`SBL_OFF_ID_DATA, `SBL_PORT_ID_DATA);
        rc(`SBL_OFF_ID_CTRL, `SBL_PORT_ID_CTRL);
        rc(8'h20, 32'h0);
        chk({31'h0, gpio_pulldown_en}, 32'h1);
        boot(3, 0, 32'h0015_0200, 4'h1);
        prog(16'h0010);
        prog(16'h0210);
        prog(16'h0800);
        gp_write();
        boot(2, 0, 32'h0000_60A3, 4'h4);
        boot(2, 1, 32'h0000_1000, 4'h4);
        prog(16'h0610);
        boot(1, 2, 32'h0000_0000, 4'h1);
        boot(0, 0, 32'h0000_0020, 4'h1);
        close_out();
    end
    initial begin
        #500_000;
        fail_count++;
        close_out();
    end
endmodule
bind sbl_loader sbl_loader_asserts u_chk (.clk(clk), .srst(srst), .rst_n_pin(rst_n_pin),
    .gpio_pulldown_en(gpio_pulldown_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_rd_en(otp_rd_en),
    .otp_rd_addr(otp_rd_addr), .otp_prog(otp_prog), .flash_byte_req(flash_byte_req),
    .ram_wr(ram_wr), .cpu_start(cpu_start), .cpu_start_addr(cpu_start_addr),
    .jtag_disable(jtag_disable), .link_access_disable(link_access_disable),
    .otp_redundant_en(otp_redundant_en), .jtag_otp_disable(jtag_otp_disable),
    .debug_pin_disable(debug_pin_disable));
`default_nettype wire
